// *** logic/scfc_channel_control.sv ***
`timescale 1ns/1ns
// How it works
// - channel off when enable bit or pin low
// - routing field picks which channels pin governs
// - drive pin filter off, 1, 4, 7 us
// - enable pin filter off, 3, 8, 15 us
// - source select: register bit or routed pin
// - driver type: off, low, high, push-pull
// - drive routing maps pins onto channels
// - polarity bit inverts drive before driver stage
// - push-pull: high on 1, low on 0
// - single-ended: switch on at 1 only
// - sync: channel b copies a, own polarity
// - sync overload turns both off, own flag
// - feedback enable bits, reset enabled
// - receive routing swaps receive outputs
// - feedback filters off, 4, 7, 16 us
// - feedback polarity bit inverts input
// - pull enable and direction per input
// - post-polarity levels readable as status
// - change flag drops on change, read restores
// - receive output equals level, pull irrelevant
// - overload shuts channel 50 ms, flag low
module scfc_channel_control
	import scfc_pkg::*;
#(
	parameter int OVL_SHUT_CYCLES = OVL_SHUT_CYC
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// register port
	input wire logic [2:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	// host control pins
	input wire logic driveInA,
	input wire logic driveInB,
	input wire logic outputEnablePin,
	// line side switches and overload detectors
	output logic lineChannelAHighOn,
	output logic lineChannelALowOn,
	output logic lineChannelBHighOn,
	output logic lineChannelBLowOn,
	input wire logic overloadDetA,
	input wire logic overloadDetB,
	// feedback inputs and receive outputs
	input wire logic lineChannelAIn,
	input wire logic feedbackInputPin,
	output logic receiveOutA,
	output logic receiveOutB,
	output logic feedbackAPullEnable,
	output logic feedbackAPullDirection,
	output logic feedbackBPullEnable,
	output logic feedbackBPullDirection
);
	localparam int OVL_W = $clog2(OVL_SHUT_CYCLES + 1);
	localparam int NPIN = 7;

	// configuration registers
	logic [5:0] chanCtl_reg; // channel_drive_control, writable part
	logic [7:0] drvCfg_reg; // output_driver_config
	logic [7:0] fbCfg_reg; // feedback_config
	logic [4:0] route_reg; // pin_routing_config
	logic [7:0] filtCfg_reg; // input_filter_config
	logic [7:0] regRdData_next; // read mux
	// write strobes per register
	logic wrChan, wrDrv, wrFb, wrRoute, wrFilt;
	logic rdEvent; // read of event_status restores change flags

	// register writes decode
	assign wrChan = regWrite && regAddr == ADDR_CHAN;
	assign wrDrv = regWrite && regAddr == ADDR_DRV;
	assign wrFb = regWrite && regAddr == ADDR_FB;
	assign wrRoute = regWrite && regAddr == ADDR_ROUTE;
	assign wrFilt = regWrite && regAddr == ADDR_FILT;
	assign rdEvent = regRead && regAddr == ADDR_EVENT;

	// config storage, read-only bits are never stored
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			chanCtl_reg <= RST_CHAN[5:0];
			drvCfg_reg <= RST_DRV;
			fbCfg_reg <= RST_FB;
			route_reg <= RST_ROUTE[4:0];
			filtCfg_reg <= RST_FILT;
		end
		else
		begin
			if (wrChan)
				chanCtl_reg <= regWrData[5:0];
			if (wrDrv)
				drvCfg_reg <= regWrData;
			if (wrFb)
				fbCfg_reg <= regWrData;
			if (wrRoute)
				route_reg <= regWrData[4:0];
			if (wrFilt)
				filtCfg_reg <= regWrData;
		end
	end

	// input filters: drive a/b, enable, line a, feedback, overload a/b
	logic [NPIN-1:0] pinRaw; // raw pins
	logic [NPIN-1:0] pinFilt; // synchronised and filtered
	logic [FILT_W-1:0] limit [NPIN]; // hold time per pin

	assign pinRaw = {overloadDetB, overloadDetA, feedbackInputPin, lineChannelAIn,
		outputEnablePin, driveInB, driveInA};
	assign limit[0] = filtLimit(filtCfg_reg[FL_TX +: 2], TX_C1, TX_C2, TX_C3);
	assign limit[1] = limit[0];
	assign limit[2] = filtLimit(filtCfg_reg[FL_OEN +: 2], OEN_C1, OEN_C2, OEN_C3);
	assign limit[3] = filtLimit(filtCfg_reg[FL_FBA +: 2], FB_C1, FB_C2, FB_C3);
	assign limit[4] = filtLimit(filtCfg_reg[FL_FBB +: 2], FB_C1, FB_C2, FB_C3);
	assign limit[5] = '0; // detectors already integrate, only synchronise
	assign limit[6] = '0;

	generate
		for (genvar p = 0; p < NPIN; p++)
		begin : gFilt
			scfc_input_filter uFilt (
				.mclk(mclk),
				.reset_n(reset_n),
				.pinIn(pinRaw[p]),
				.limit(limit[p]),
				.levelOut(pinFilt[p])
			);
		end
	endgenerate

	// overload shutdown per channel
	logic [1:0] ovlShut; // channel is in its shutdown period
	generate
		for (genvar c = 0; c < 2; c++)
		begin : gOvl
			scfc_ovl_type state_reg; // run or shut
			logic [OVL_W-1:0] count_reg; // cycles left in shutdown
			always_ff @(posedge mclk)
			begin
				if (!reset_n)
				begin
					state_reg <= OVL_RUN;
					count_reg <= '0;
				end
				else
					case (state_reg)
						OVL_RUN:
							if (pinFilt[5 + c])
							begin
								state_reg <= OVL_SHUT;
								count_reg <= OVL_W'(OVL_SHUT_CYCLES - 1);
							end
						OVL_SHUT:
							if (count_reg == '0)
								state_reg <= OVL_RUN; // flag restored
							else
								count_reg <= count_reg - OVL_W'(1);
						default:
							state_reg <= OVL_RUN;
					endcase
			end
			assign ovlShut[c] = state_reg == OVL_SHUT;
		end
	endgenerate

	// drive routing and source selection
	logic syncMode; // channel b slaved to a
	logic pinForA, pinForB; // routed drive pins
	logic srcA, srcB; // selected drive before polarity
	logic xorA, xorB; // after polarity
	logic effEnA, effEnB; // enable after pin routing
	logic offA, offB; // overload forces off
	logic [1:0] typeB; // effective type of channel b

	assign syncMode = drvCfg_reg[DC_SYNC];
	assign pinForA = route_reg[RT_DRIVE +: 2] inside {2'h1, 2'h3} ? pinFilt[1] : pinFilt[0];
	assign pinForB = route_reg[RT_DRIVE +: 2] inside {2'h2, 2'h3} ? pinFilt[1] : pinFilt[0];
	assign srcA = chanCtl_reg[CH_SRC_A] ? pinForA : chanCtl_reg[CH_DRV_A];
	assign srcB = chanCtl_reg[CH_SRC_B] ? pinForB : chanCtl_reg[CH_DRV_B];
	assign xorA = srcA ^ drvCfg_reg[DC_POL_A];
	// sync keeps only b polarity, so complementary outputs are possible
	assign xorB = (syncMode ? srcA : srcB) ^ drvCfg_reg[DC_POL_B];
	assign typeB = syncMode ? drvCfg_reg[DC_TYPE_A +: 2] : drvCfg_reg[DC_TYPE_B +: 2];
	// a pin-governed channel ignores its enable bit
	assign effEnA = route_reg[RT_OEN] ? pinFilt[2] : chanCtl_reg[CH_EN_A];
	assign effEnB = syncMode ? effEnA :
		(route_reg[RT_OEN + 1] ? pinFilt[2] : chanCtl_reg[CH_EN_B]);
	assign offA = ovlShut[0] || (syncMode && ovlShut[1]);
	assign offB = ovlShut[1] || (syncMode && ovlShut[0]);

	// driver stages
	scfc_output_stage uStageA (
		.mclk(mclk),
		.reset_n(reset_n),
		.drive(xorA),
		.driverType(drvCfg_reg[DC_TYPE_A +: 2]),
		.enable(effEnA && !offA),
		.highOn(lineChannelAHighOn),
		.lowOn(lineChannelALowOn)
	);
	scfc_output_stage uStageB (
		.mclk(mclk),
		.reset_n(reset_n),
		.drive(xorB),
		.driverType(typeB),
		.enable(effEnB && !offB),
		.highOn(lineChannelBHighOn),
		.lowOn(lineChannelBLowOn)
	);

	// feedback levels; a disabled path reads low
	logic [1:0] level; // after polarity and enable
	logic [1:0] levelPrev_reg; // for change detection
	logic [1:0] levelChange; // level moved this cycle
	logic [1:0] chgN_reg; // change flags, low after a change
	logic [1:0] chgN_next;

	generate
		for (genvar f = 0; f < 2; f++)
		begin : gFb
			assign level[f] = fbCfg_reg[FB_EN + f * FB_STRIDE] &&
				(pinFilt[3 + f] ^ fbCfg_reg[FB_POL + f * FB_STRIDE]);
			assign levelChange[f] = level[f] != levelPrev_reg[f];
			// a change in the read cycle wins, so no edge is lost
			assign chgN_next[f] = levelChange[f] ? 1'b0 : (rdEvent ? 1'b1 : chgN_reg[f]);
		end
	endgenerate

	// feedback state and receive outputs
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			levelPrev_reg <= '0;
			chgN_reg <= 2'h3;
			receiveOutA <= 1'b0;
			receiveOutB <= 1'b0;
		end
		else
		begin
			levelPrev_reg <= level;
			chgN_reg <= chgN_next;
			receiveOutA <= route_reg[RT_RX] ? level[1] : level[0];
			receiveOutB <= route_reg[RT_RX] ? level[0] : level[1];
		end
	end

	// pull current controls come straight from the register
	assign feedbackAPullEnable = fbCfg_reg[FB_PULL_EN];
	assign feedbackAPullDirection = fbCfg_reg[FB_PULL_DIR];
	assign feedbackBPullEnable = fbCfg_reg[FB_PULL_EN + FB_STRIDE];
	assign feedbackBPullDirection = fbCfg_reg[FB_PULL_DIR + FB_STRIDE];

	// read mux; wake-up detection is absent so its flag idles high
	always_comb
	begin
		regRdData_next = 8'h00;
		case (regAddr)
			ADDR_EVENT:
			begin
				regRdData_next[EV_WAKE_N] = 1'b1;
				regRdData_next[EV_CHG +: 2] = chgN_reg;
				regRdData_next[EV_OVL +: 2] = ~ovlShut;
			end
			ADDR_CHAN: regRdData_next = {level, chanCtl_reg};
			ADDR_DRV: regRdData_next = drvCfg_reg;
			ADDR_FB: regRdData_next = fbCfg_reg;
			ADDR_ROUTE: regRdData_next = {3'h0, route_reg};
			ADDR_FILT: regRdData_next = filtCfg_reg;
			default: regRdData_next = 8'h00;
		endcase
	end

	// read data captured on the read strobe, held until the next one
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			regRdData <= 8'h00;
		else if (regRead)
			regRdData <= regRdData_next;
	end

	// checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);

	AST_ENABLE_OFF: assert property (
		!effEnA |=> !lineChannelAHighOn && !lineChannelALowOn)
		else $error("channel a drives while disabled");
	AST_PIN_ROUTE: assert property (
		route_reg[RT_OEN +: 2] == 2'h3 && !pinFilt[2] && !syncMode
		|=> !lineChannelBHighOn && !lineChannelBLowOn)
		else $error("enable pin did not gate channel b");
	AST_TX_LIMIT: assert property (
		filtCfg_reg[FL_TX +: 2] == 2'h3 |-> limit[0] == TX_C3)
		else $error("drive filter time wrong");
	AST_TYPE_OFF: assert property (
		drvCfg_reg[DC_TYPE_A +: 2] == DT_HIZ |=> !lineChannelAHighOn && !lineChannelALowOn)
		else $error("channel a active in off type");
	AST_PUSH_PULL: assert property (
		effEnA && !offA && drvCfg_reg[DC_TYPE_A +: 2] == DT_PP
		|=> lineChannelAHighOn == $past(xorA) && lineChannelALowOn == !$past(xorA))
		else $error("push-pull switch mismatch");
	AST_LOW_SIDE: assert property (
		effEnA && !offA && drvCfg_reg[DC_TYPE_A +: 2] == DT_LOW
		|=> lineChannelALowOn == $past(xorA) && !lineChannelAHighOn)
		else $error("low-side switch mismatch");
	AST_SYNC_COPY: assert property (
		syncMode && drvCfg_reg[DC_POL_A] != drvCfg_reg[DC_POL_B] && effEnA && !offA
		&& drvCfg_reg[DC_TYPE_A +: 2] == DT_PP |=> lineChannelBHighOn == lineChannelALowOn)
		else $error("sync outputs not complementary");
	AST_SYNC_OVL: assert property (
		syncMode && ovlShut[0] |=> !lineChannelBHighOn && !lineChannelBLowOn)
		else $error("sync overload left channel b on");
	AST_RX_ROUTE: assert property (
		route_reg[RT_RX] |=> receiveOutA == $past(level[1]))
		else $error("receive routing not swapped");
	AST_CHG_WINS: assert property (
		levelChange[0] && rdEvent |=> !chgN_reg[0])
		else $error("change lost against read");
	AST_OVL_HOLD: assert property (
		$rose(ovlShut[0]) |-> ovlShut[0] [*8])
		else $error("shutdown ended early");

	COV_SYNC_PP: cover property (syncMode && lineChannelAHighOn && lineChannelBLowOn);
	COV_OVL: cover property ($fell(ovlShut[1]));
	COV_CHG_READ: cover property (!chgN_reg[1] ##1 rdEvent ##1 chgN_reg[1]);
	COV_RX_SWAP: cover property (route_reg[RT_RX] && receiveOutA);
endmodule : scfc_channel_control

// *** logic/scfc_input_filter.sv ***
`timescale 1ns/1ns
module scfc_input_filter
	import scfc_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// raw pin and hold time
	input wire logic pinIn,
	input wire logic [FILT_W-1:0] limit,
	// filtered level
	output logic levelOut
);
	logic syncA_reg; // first stage, read only by syncB_reg
	logic syncB_reg; // second stage
	logic [FILT_W-1:0] count_reg; // cycles the new level has held
	logic differs; // synced pin disagrees with output
	logic heldLong; // new level held for the full time

	assign differs = syncB_reg != levelOut;
	assign heldLong = count_reg >= limit - FILT_W'(1);

	// two-stage synchroniser, pins are asynchronous to mclk
	always_ff @(posedge mclk)
	begin
		syncA_reg <= reset_n ? pinIn : 1'b0;
		syncB_reg <= reset_n ? syncA_reg : 1'b0;
	end

	// any bounce restarts the count, so only a steady level passes
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			count_reg <= '0;
			levelOut <= 1'b0;
		end
		else if (!differs)
			count_reg <= '0;
		else if (limit == '0 || heldLong)
		begin
			levelOut <= syncB_reg;
			count_reg <= '0;
		end
		else
			count_reg <= count_reg + FILT_W'(1);
	end
endmodule : scfc_input_filter

// *** logic/scfc_output_stage.sv ***
`timescale 1ns/1ns
module scfc_output_stage
	import scfc_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// drive after polarity, type and gate
	input wire logic drive,
	input wire logic [1:0] driverType,
	input wire logic enable,
	// switch controls
	output logic highOn,
	output logic lowOn
);
	logic highNext; // high-side switch wanted
	logic lowNext; // low-side switch wanted

	// when enabled, push-pull drives one side; single-ended types only on a 1
	assign highNext = enable && drive &&
		(driverType == DT_HIGH || driverType == DT_PP);
	assign lowNext = enable && ((drive && driverType == DT_LOW) ||
		(!drive && driverType == DT_PP));

	// registered so the switches never see a decode glitch
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			highOn <= 1'b0;
			lowOn <= 1'b0;
		end
		else
		begin
			highOn <= highNext;
			lowOn <= lowNext;
		end
	end
endmodule : scfc_output_stage

// *** logic/scfc_pkg.sv ***
package scfc_pkg;
	// register indices on the parallel register port
	localparam logic [2:0] ADDR_EVENT = 3'h0;
	localparam logic [2:0] ADDR_CHAN = 3'h1;
	localparam logic [2:0] ADDR_DRV = 3'h2;
	localparam logic [2:0] ADDR_FB = 3'h5;
	localparam logic [2:0] ADDR_ROUTE = 3'h6;
	localparam logic [2:0] ADDR_FILT = 3'h7;
	// reset values and writable bits
	localparam logic [7:0] RST_CHAN = 8'h00;
	localparam logic [7:0] RST_DRV = 8'h33;
	localparam logic [7:0] RST_FB = 8'h55;
	localparam logic [7:0] RST_ROUTE = 8'h02;
	localparam logic [7:0] RST_FILT = 8'h96;
	localparam logic [7:0] MASK_CHAN = 8'h3f;
	localparam logic [7:0] MASK_ROUTE = 8'h1f;
	// channel_drive_control fields
	localparam int CH_DRV_A = 0;
	localparam int CH_EN_A = 1;
	localparam int CH_SRC_A = 2;
	localparam int CH_DRV_B = 3;
	localparam int CH_EN_B = 4;
	localparam int CH_SRC_B = 5;
	localparam int CH_LVL_A = 6;
	// output_driver_config fields
	localparam int DC_TYPE_A = 0;
	localparam int DC_POL_A = 2;
	localparam int DC_TYPE_B = 4;
	localparam int DC_POL_B = 6;
	localparam int DC_SYNC = 7;
	// feedback_config fields, channel b sits FB_STRIDE above channel a
	localparam int FB_EN = 0;
	localparam int FB_POL = 1;
	localparam int FB_PULL_EN = 2;
	localparam int FB_PULL_DIR = 3;
	localparam int FB_STRIDE = 4;
	// pin_routing_config and input_filter_config fields
	localparam int RT_DRIVE = 0;
	localparam int RT_RX = 2;
	localparam int RT_OEN = 3;
	localparam int FL_TX = 0;
	localparam int FL_FBA = 2;
	localparam int FL_FBB = 4;
	localparam int FL_OEN = 6;
	// event_status fields
	localparam int EV_WAKE_N = 0;
	localparam int EV_CHG = 2;
	localparam int EV_OVL = 4;
	// driver types
	localparam logic [1:0] DT_HIZ = 2'h0;
	localparam logic [1:0] DT_LOW = 2'h1;
	localparam logic [1:0] DT_HIGH = 2'h2;
	localparam logic [1:0] DT_PP = 2'h3;
	// filter times in ns, converted to whole 40 ns cycles, rounded up
	localparam int CLK_NS = 40;
	localparam int FILT_W = 9;
	localparam logic [FILT_W-1:0] TX_C1 = FILT_W'((1000 + CLK_NS - 1) / CLK_NS);
	localparam logic [FILT_W-1:0] TX_C2 = FILT_W'((4000 + CLK_NS - 1) / CLK_NS);
	localparam logic [FILT_W-1:0] TX_C3 = FILT_W'((7000 + CLK_NS - 1) / CLK_NS);
	localparam logic [FILT_W-1:0] OEN_C1 = FILT_W'((3000 + CLK_NS - 1) / CLK_NS);
	localparam logic [FILT_W-1:0] OEN_C2 = FILT_W'((8000 + CLK_NS - 1) / CLK_NS);
	localparam logic [FILT_W-1:0] OEN_C3 = FILT_W'((15000 + CLK_NS - 1) / CLK_NS);
	localparam logic [FILT_W-1:0] FB_C1 = FILT_W'((4000 + CLK_NS - 1) / CLK_NS);
	localparam logic [FILT_W-1:0] FB_C2 = FILT_W'((7000 + CLK_NS - 1) / CLK_NS);
	localparam logic [FILT_W-1:0] FB_C3 = FILT_W'((16000 + CLK_NS - 1) / CLK_NS);
	// overload shutdown, 50 ms, rounded down to cycles
	localparam int OVL_SHUT_MS = 50;
	localparam int OVL_SHUT_CYC = OVL_SHUT_MS * 1000000 / CLK_NS;
	// overload state per channel
	typedef enum {OVL_RUN, OVL_SHUT} scfc_ovl_type;

	// filter setting to hold time in cycles, zero means bypass
	function automatic logic [FILT_W-1:0] filtLimit(input logic [1:0] sel,
		input logic [FILT_W-1:0] t1, input logic [FILT_W-1:0] t2, input logic [FILT_W-1:0] t3);
		case (sel)
			2'h1: return t1;
			2'h2: return t2;
			2'h3: return t3;
			default: return '0;
		endcase
	endfunction : filtLimit
endpackage : scfc_pkg

// *** tb/scfc_line_model.sv ***
`timescale 1ns/1ns
// line-side load on channel a: follows the switches, else the pull current
module scfc_line_model
(
	// clock
	input wire logic mclk,
	// switch controls and pull settings
	input wire logic highOn,
	input wire logic lowOn,
	input wire logic pullEnable,
	input wire logic pullDirection,
	// resulting line level
	output logic lineLevel
);
	// an unpulled open line wanders, so it never reads as a steady level
	logic floatLevel = 1'b0;

	// toggles every cycle to stand in for a floating line
	always_ff @(posedge mclk)
	begin
		floatLevel <= ~floatLevel;
	end

	// a switch that is on wins, then the pull current, else the float
	assign lineLevel = highOn ? 1'b1 : lowOn ? 1'b0 : pullEnable ? pullDirection : floatLevel;
endmodule : scfc_line_model

// *** tb/scfc_tb.sv ***
`timescale 1ns/1ns
module tb
	import scfc_pkg::*;
;
	// clock, reset and bookkeeping
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	int nFail = 0;
	int nCompared = 0;
	int cycles = 0;
	// register port
	logic [2:0] regAddr = 3'h0;
	logic [7:0] regWrData = 8'h00;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [7:0] regRdData;
	// host pins and line side
	logic driveInA = 1'b0;
	logic driveInB = 1'b0;
	logic outputEnablePin = 1'b0;
	logic ovlA = 1'b0;
	logic ovlB = 1'b0;
	logic fbPin = 1'b0;
	logic lineA, aHigh, aLow, bHigh, bLow, rxA, rxB;
	logic pullEnA, pullDirA, pullEnB, pullDirB;
	// outputs packed for comparison
	wire [7:0] swState = {4'h0, aHigh, aLow, bHigh, bLow};
	wire [7:0] fbState = {2'h0, rxA, rxB, pullEnA, pullDirA, pullEnB, pullDirB};
	// reset table, last entry an unmapped index
	localparam logic [0:6][2:0] R_ADDR = {3'h0, 3'h1, 3'h2, 3'h5, 3'h6, 3'h7, 3'h3};
	localparam logic [0:6][7:0] R_VAL = {8'h3d, 8'h00, 8'h33, 8'h55, 8'h02, 8'h96, 8'h00};

	// short shutdown keeps the overload test brief
	scfc_channel_control #(.OVL_SHUT_CYCLES(16)) dut_u
	(
		.mclk(mclk), .reset_n(reset_n),
		.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
		.regRead(regRead), .regRdData(regRdData),
		.driveInA(driveInA), .driveInB(driveInB), .outputEnablePin(outputEnablePin),
		.lineChannelAHighOn(aHigh), .lineChannelALowOn(aLow),
		.lineChannelBHighOn(bHigh), .lineChannelBLowOn(bLow),
		.overloadDetA(ovlA), .overloadDetB(ovlB),
		.lineChannelAIn(lineA), .feedbackInputPin(fbPin),
		.receiveOutA(rxA), .receiveOutB(rxB),
		.feedbackAPullEnable(pullEnA), .feedbackAPullDirection(pullDirA),
		.feedbackBPullEnable(pullEnB), .feedbackBPullDirection(pullDirB)
	);

	// load on channel a closes the feedback loop
	scfc_line_model line_u
	(
		.mclk(mclk), .highOn(aHigh), .lowOn(aLow),
		.pullEnable(pullEnA), .pullDirection(pullDirA), .lineLevel(lineA)
	);

	// free-running clock
	initial
	begin
		forever #20 mclk = ~mclk;
	end

	// hang guard, far above the roughly 1300 cycles needed
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			nFail++;
			finishTest();
		end
	end

	task automatic finishTest();
		if (nFail == 0 && nCompared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finishTest

	// one write strobe, then one idle edge so back-to-back calls never retoggle it
	task automatic wrReg(input logic [2:0] a, input logic [7:0] d);
		regAddr = a;
		regWrData = d;
		regWrite = 1'b1;
		@(negedge mclk);
		regWrite = 1'b0;
		@(negedge mclk);
	endtask : wrReg

	// one read strobe, data taken once it stands
	task automatic rdReg(input logic [2:0] a, output logic [7:0] d);
		regAddr = a;
		regRead = 1'b1;
		@(negedge mclk);
		regRead = 1'b0;
		@(negedge mclk);
		d = regRdData;
	endtask : rdReg

	// sync flops, filter and output stage all land within this
	task automatic settle();
		repeat (6) @(negedge mclk);
	endtask : settle

	task automatic cmpVal(input string nm, input logic [7:0] e, input logic [7:0] g);
		nCompared++;
		if (g !== e)
		begin
			nFail++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask : cmpVal

	// main sequence
	initial
	begin
		logic [7:0] v;
		logic d, h, l, ea, eb, la, lb;
		repeat (3) @(negedge mclk);
		reset_n = 1'b1;
		// reset values and refused writes
		for (int i = 0; i < 7; i++)
		begin
			rdReg(R_ADDR[i], v);
			cmpVal("reset", R_VAL[i], v);
		end
		wrReg(ADDR_ROUTE, 8'hff);
		wrReg(3'h3, 8'hff);
		rdReg(ADDR_ROUTE, v);
		cmpVal("readonly", 8'h1f, v);
		// back to reset routing so the enable bits govern again
		wrReg(ADDR_ROUTE, 8'h02);
		rdReg(3'h3, v);
		cmpVal("unmapped", 8'h00, v);
		wrReg(ADDR_FILT, 8'h00);
		// driver type, polarity and drive bit on both channels
		for (int i = 0; i < 16; i++)
		begin
			wrReg(ADDR_DRV, {1'b0, i[2], i[1:0], 1'b0, i[2], i[1:0]});
			wrReg(ADDR_CHAN, {2'h0, 1'b0, 1'b1, i[3], 1'b0, 1'b1, i[3]});
			settle();
			d = i[3] ^ i[2];
			h = i[1] & d;
			l = i[0] & (i[1] ^ d);
			cmpVal("type", {4'h0, h, l, h, l}, swState);
		end
		// enable bits against the routed enable pin
		wrReg(ADDR_DRV, 8'h33);
		for (int i = 0; i < 32; i++)
		begin
			outputEnablePin = i[2];
			wrReg(ADDR_ROUTE, {3'h0, i[1:0], 3'h2});
			wrReg(ADDR_CHAN, {2'h0, 1'b0, i[4], 1'b1, 1'b0, i[3], 1'b1});
			settle();
			ea = i[0] ? i[2] : i[3];
			eb = i[1] ? i[2] : i[4];
			cmpVal("enable", {4'h0, ea, 1'b0, eb, 1'b0}, swState);
		end
		// pin source and drive routing
		wrReg(ADDR_CHAN, 8'h36);
		for (int i = 0; i < 16; i++)
		begin
			driveInA = i[2];
			driveInB = i[3];
			wrReg(ADDR_ROUTE, {6'h0, i[1:0]});
			settle();
			ea = i[0] ? i[3] : i[2];
			eb = i[1] ? i[3] : i[2];
			cmpVal("route", {4'h0, ea, ~ea, eb, ~eb}, swState);
		end
		// sync mode, channel b settings other than polarity ignored
		for (int i = 0; i < 4; i++)
		begin
			wrReg(ADDR_DRV, {1'b1, i[0], 2'h1, 4'h3});
			wrReg(ADDR_CHAN, {2'h0, 1'b0, 1'b0, ~i[1], 1'b0, 1'b1, i[1]});
			settle();
			d = i[1] ^ i[0];
			cmpVal("sync", {4'h0, i[1], ~i[1], d, ~d}, swState);
		end
		// overload on a in sync mode shuts both, flags only a
		rdReg(ADDR_EVENT, v);
		ovlA = 1'b1;
		repeat (2) @(negedge mclk);
		ovlA = 1'b0;
		repeat (4) @(negedge mclk);
		cmpVal("ovlout", 8'h00, swState);
		rdReg(ADDR_EVENT, v);
		cmpVal("ovlflag", 8'h20, v & 8'h30);
		repeat (30) @(negedge mclk);
		rdReg(ADDR_EVENT, v);
		cmpVal("ovlend", 8'h30, v & 8'h30);
		cmpVal("ovlback", 8'h09, swState);
		// feedback polarity, pull direction and receive routing
		wrReg(ADDR_CHAN, 8'h00);
		for (int i = 0; i < 16; i++)
		begin
			wrReg(ADDR_ROUTE, {5'h0, i[3], 2'h2});
			wrReg(ADDR_FB, {i[0], 1'b1, i[1], 1'b1, i[0], 1'b1, i[1], 1'b1});
			fbPin = i[2];
			settle();
			la = i[0] ^ i[1];
			lb = i[2] ^ i[1];
			rdReg(ADDR_CHAN, v);
			cmpVal("level", {lb, la, 6'h0}, v & 8'hc0);
			ea = i[3] ? lb : la;
			eb = i[3] ? la : lb;
			cmpVal("rx", {2'h0, ea, eb, 1'b1, i[0], 1'b1, i[0]}, fbState);
		end
		// change flag drops on a change, read restores it
		rdReg(ADDR_EVENT, v);
		fbPin = ~fbPin;
		settle();
		rdReg(ADDR_EVENT, v);
		cmpVal("change", 8'h04, v & 8'h0c);
		rdReg(ADDR_EVENT, v);
		cmpVal("cleared", 8'h0c, v & 8'h0c);
		// disabled feedback b reads low whatever the pin
		wrReg(ADDR_ROUTE, 8'h02);
		wrReg(ADDR_FB, 8'h45);
		fbPin = 1'b1;
		settle();
		cmpVal("fboff", 8'h0a, fbState);
		// feedback b filter at 100 cycles: early level held back, bounce restarts count
		wrReg(ADDR_FB, 8'h55);
		wrReg(ADDR_FILT, 8'h10);
		fbPin = 1'b0;
		repeat (150) @(negedge mclk);
		fbPin = 1'b1;
		repeat (80) @(negedge mclk);
		cmpVal("glitch", 8'h00, fbState & 8'h10);
		fbPin = 1'b0;
		@(negedge mclk);
		fbPin = 1'b1;
		repeat (80) @(negedge mclk);
		cmpVal("bounce", 8'h00, fbState & 8'h10);
		repeat (40) @(negedge mclk);
		cmpVal("filtered", 8'h10, fbState & 8'h10);
		finishTest();
	end
endmodule : tb
